/* core/ext_irq_edge_detect_filter.sv */
// edge detector for the nmi pin and nine external request pins, with digital filter on pin 3
// assumes a single AHB-Lite master, pins asynchronous to hclk, analog filters outside
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module ext_irq_edge_detect_filter
	import ext_irq_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        nmi_pin,
	input  wire logic        ext_request_pin_0,
	input  wire logic        ext_request_pin_1,
	input  wire logic        ext_request_pin_2,
	input  wire logic        ext_request_pin_3,
	input  wire logic        ext_request_pin_4,
	input  wire logic        ext_request_pin_5,
	input  wire logic        ext_request_pin_6,
	input  wire logic        ext_request_pin_7,
	input  wire logic        ext_request_pin_8,
	input  wire logic        sub_clock_pin,
	input  wire logic        standby_mode,
	output logic             nmi_request,
	output logic             ext_request_0,
	output logic             ext_request_1,
	output logic             ext_request_2,
	output logic             ext_request_3,
	output logic             ext_request_4,
	output logic             ext_request_5,
	output logic             ext_request_6,
	output logic             ext_request_7,
	output logic             ext_request_8,
	output logic             wake_request
);
	logic [7:0]               edge_fall_select_0;
	logic [7:0]               edge_rise_select_0;
	logic [7:0]               edge_fall_select_3;
	logic [7:0]               edge_rise_select_3;
	logic [7:0]               edge_fall_select_8;
	logic [7:0]               edge_rise_select_8;
	logic [7:0]               edge_fall_select_9_upper;
	logic [7:0]               edge_rise_select_9_upper;
	logic [7:0]               noise_filter_control;
	bus_state_t               bus_state;
	logic                     wr_pending;
	logic [7:0]               wr_addr;
	logic [7:0]               rd_addr;
	logic [9:0]               pin_raw;
	logic [9:0]               sync1;
	logic [9:0]               sync2;
	logic                     sub_sync1;
	logic                     sub_sync2;
	logic                     sub_prev;
	logic [PRESCALE_BITS-1:0] prescale;
	logic [2:0]               sel_prev;
	logic [1:0]               init_count;
	logic [2:0]               samples;
	logic [2:0]               next_samples;
	logic                     filt_level;
	logic                     tick;
	logic                     digital_filter_select;
	logic [2:0]               sample_sel;
	logic                     pin3_can_wake;
	logic [9:0]               level;
	logic [9:0]               prev_level;
	logic [9:0]               fall_sel;
	logic [9:0]               rise_sel;
	logic [9:0]               hit;
	logic [9:0]               req;
	logic [31:0]              read_value;
	logic                     accept;

	function automatic logic edge_hit(input logic lvl, input logic prv,
			input logic f, input logic r);
		return (f & prv & ~lvl) | (r & ~prv & lvl);
	endfunction : edge_hit

	function automatic logic sample_tick(input logic [2:0] sel,
			input logic [PRESCALE_BITS-1:0] cnt, input logic sub_edge);
		case (sel)
			SEL_DIV64:   return &cnt[5:0];
			SEL_DIV128:  return &cnt[6:0];
			SEL_DIV256:  return &cnt[7:0];
			SEL_DIV512:  return &cnt[8:0];
			SEL_DIV1024: return &cnt[9:0];
			SEL_SUB:     return sub_edge;
			default:     return 1'b0;
		endcase
	endfunction : sample_tick

	// ---- bus slave ----
	assign accept    = hsel & hready & htrans[1];
	assign hreadyout = (bus_state != BUS_READ_WAIT);
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state  <= BUS_IDLE;
			wr_pending <= 1'b0;
			wr_addr    <= 8'h00;
			rd_addr    <= 8'h00;
		end else begin
			wr_pending <= accept & hwrite;
			if (accept) begin
				wr_addr <= haddr[7:0];
				rd_addr <= haddr[7:0];
			end
			case (bus_state)
				BUS_IDLE: begin
					if (accept && !hwrite)
						bus_state <= BUS_READ_WAIT;
				end
				BUS_READ_WAIT: bus_state <= BUS_IDLE;
				default:       bus_state <= BUS_IDLE;
			endcase
		end
	end

	// one wait state on reads so a preceding write is always visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (bus_state == BUS_READ_WAIT)
			hrdata <= read_value;
	end

	always_comb begin
		read_value = 32'h0000_0000;
		case (rd_addr)
			OFS_FALL_0:       read_value[7:0] = edge_fall_select_0;
			OFS_RISE_0:       read_value[7:0] = edge_rise_select_0;
			OFS_FALL_3:       read_value[7:0] = edge_fall_select_3;
			OFS_RISE_3:       read_value[7:0] = edge_rise_select_3;
			OFS_FALL_8:       read_value[7:0] = edge_fall_select_8;
			OFS_RISE_8:       read_value[7:0] = edge_rise_select_8;
			OFS_FALL_9_UPPER: read_value[7:0] = edge_fall_select_9_upper;
			OFS_RISE_9_UPPER: read_value[7:0] = edge_rise_select_9_upper;
			OFS_FILTER_CTRL:  read_value[7:0] = noise_filter_control;
			OFS_STATUS: begin
				read_value[9:0]          = level;
				read_value[STATUS_READY] = (init_count == FILTER_INIT_TICKS);
			end
			default:          read_value = 32'h0000_0000;
		endcase
	end

	// byte lane 0 carries every writable register, so byte, half and word writes all land
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_fall_select_0       <= RST_SELECT; // see RULE3
			edge_rise_select_0       <= RST_SELECT;
			edge_fall_select_3       <= RST_SELECT;
			edge_rise_select_3       <= RST_SELECT;
			edge_fall_select_8       <= RST_SELECT;
			edge_rise_select_8       <= RST_SELECT;
			edge_fall_select_9_upper <= RST_SELECT;
			edge_rise_select_9_upper <= RST_SELECT;
			noise_filter_control     <= RST_FILTER_CTRL;
		end else if (wr_pending && wr_addr[1:0] == 2'b00) begin // see RULE7
			case (wr_addr)
				OFS_FALL_0:       edge_fall_select_0       <= hwdata[7:0] & MASK_GROUP0;
				OFS_RISE_0:       edge_rise_select_0       <= hwdata[7:0] & MASK_GROUP0;
				OFS_FALL_3:       edge_fall_select_3       <= hwdata[7:0] & MASK_GROUP3;
				OFS_RISE_3:       edge_rise_select_3       <= hwdata[7:0] & MASK_GROUP3;
				OFS_FALL_8:       edge_fall_select_8       <= hwdata[7:0] & MASK_GROUP8;
				OFS_RISE_8:       edge_rise_select_8       <= hwdata[7:0] & MASK_GROUP8;
				OFS_FALL_9_UPPER: edge_fall_select_9_upper <= hwdata[7:0] & MASK_GROUP9;
				OFS_RISE_9_UPPER: edge_rise_select_9_upper <= hwdata[7:0] & MASK_GROUP9;
				OFS_FILTER_CTRL:  noise_filter_control     <= hwdata[7:0] & MASK_FILTER;
				default: ;
			endcase
		end
	end

	// ---- pin synchronisers, index 0 nmi, index n+1 request pin n ----
	assign pin_raw = {ext_request_pin_8, ext_request_pin_7, ext_request_pin_6,
		ext_request_pin_5, ext_request_pin_4, ext_request_pin_3, ext_request_pin_2,
		ext_request_pin_1, ext_request_pin_0, nmi_pin};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1     <= 10'h000;
			sync2     <= 10'h000;
			sub_sync1 <= 1'b0;
			sub_sync2 <= 1'b0;
			sub_prev  <= 1'b0;
		end else begin
			sync1     <= pin_raw; // see RULE19
			sync2     <= sync1;
			sub_sync1 <= sub_clock_pin;
			sub_sync2 <= sub_sync1;
			sub_prev  <= sub_sync2;
		end
	end

	// ---- digital filter on pin 3 ----
	assign digital_filter_select = noise_filter_control[FILTER_EN_BIT];
	assign sample_sel            = noise_filter_control[2:0];
	assign tick = sample_tick(sample_sel, prescale, sub_sync2 & ~sub_prev); // see RULE12
	assign next_samples          = {samples[1:0], sync2[4]};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			prescale <= '0;
		else
			prescale <= prescale + 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_prev   <= RST_FILTER_CTRL[2:0];
			init_count <= 2'h0;
			samples    <= 3'h0;
			filt_level <= 1'b0;
		end else begin
			sel_prev <= sample_sel;
			if (sample_sel != sel_prev)
				init_count <= 2'h0; // see RULE15
			else if (tick && init_count != FILTER_INIT_TICKS)
				init_count <= init_count + 2'h1;
			if (tick)
				samples <= next_samples;
			// short glitches that line up with three ticks still pass, see RULE14
			if (tick && init_count == FILTER_INIT_TICKS
					&& (&next_samples || ~|next_samples))
				filt_level <= next_samples[0]; // see RULE13
		end
	end

	// ---- edge detection ----
	always_comb begin
		level    = sync2;
		level[4] = digital_filter_select ? filt_level : sync2[4]; // see RULE11
	end

	always_comb begin
		fall_sel    = 10'h000;
		rise_sel    = 10'h000;
		fall_sel[0] = edge_fall_select_0[NMI_BIT]; // see RULE2
		rise_sel[0] = edge_rise_select_0[NMI_BIT];
		for (int i = 0; i < 4; i++) begin
			fall_sel[i+1] = edge_fall_select_0[GROUP0_FIRST+i];
			rise_sel[i+1] = edge_rise_select_0[GROUP0_FIRST+i];
		end
		for (int i = 0; i < 3; i++) begin
			fall_sel[i+5] = edge_fall_select_9_upper[GROUP9_FIRST+i]; // see RULE6
			rise_sel[i+5] = edge_rise_select_9_upper[GROUP9_FIRST+i];
		end
		fall_sel[8] = edge_fall_select_3[PIN7_BIT]; // see RULE4
		rise_sel[8] = edge_rise_select_3[PIN7_BIT];
		fall_sel[9] = edge_fall_select_8[PIN8_BIT]; // see RULE5
		rise_sel[9] = edge_rise_select_8[PIN8_BIT];
	end

	always_comb begin
		for (int i = 0; i < 10; i++)
			// clearing both selects stops detection at once, see RULE8
			hit[i] = edge_hit(level[i], prev_level[i], fall_sel[i], rise_sel[i]); // see RULE1
	end

	// pin 3 can wake with its digital filter off, or when its filter clock keeps running in standby
	assign pin3_can_wake = !digital_filter_select || sample_sel == SEL_SUB; // see RULE17

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_level   <= 10'h000;
			req          <= 10'h000;
			wake_request <= 1'b0;
		end else begin
			prev_level   <= level;
			req          <= hit; // see RULE20
			// nmi bypasses every clocked filter, see RULE18
			wake_request <= standby_mode
				&& ((hit & 10'h3EF) != 10'h000 || (hit[4] && pin3_can_wake));
		end
	end

	assign nmi_request   = req[0];
	assign ext_request_0 = req[1];
	assign ext_request_1 = req[2];
	assign ext_request_2 = req[3];
	assign ext_request_3 = req[4];
	assign ext_request_4 = req[5];
	assign ext_request_5 = req[6];
	assign ext_request_6 = req[7];
	assign ext_request_7 = req[8];
	assign ext_request_8 = req[9];

	// ---- checks ----
	nmi_disabled_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE3
		(!fall_sel[0] && !rise_sel[0]) |=> !nmi_request)
		else $error("nmi request without selected edge");

	rise_only_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE1
		(rise_sel[1] && level[1] && !prev_level[1]) |=> ext_request_0)
		else $error("rising edge on pin 0 not reported");

	fall_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE1
		(!fall_sel[1] && !level[1] && prev_level[1]) |=> !ext_request_0)
		else $error("falling edge on pin 0 reported though not selected");

	pin3_map_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE2
		(edge_fall_select_0[6] && !level[4] && prev_level[4]) |=> ext_request_3)
		else $error("pin 3 falling edge not reported");

	pin7_map_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE4
		(edge_rise_select_3[1] && level[8] && !prev_level[8]) |=> ext_request_7)
		else $error("pin 7 rising edge not reported");

	pin8_map_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE5
		(edge_fall_select_8[0] && !level[9] && prev_level[9]) |=> ext_request_8)
		else $error("pin 8 falling edge not reported");

	pin6_map_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE6
		(edge_rise_select_9_upper[7] && level[7] && !prev_level[7]) |=> ext_request_6)
		else $error("pin 6 rising edge not reported");

	sync_depth_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE19
		##2 sync2[3] == $past(ext_request_pin_2, 2))
		else $error("pin 2 synchroniser depth wrong");

	request_cause_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE20
		nmi_request |-> $past(level[0] != prev_level[0]))
		else $error("nmi request without level change");

	filter_agree_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE13
		$changed(filt_level) |-> $past(tick) && $past(init_count) == 2'h3
			&& $past(samples[1:0]) == {2{filt_level}})
		else $error("filter output moved without three agreeing samples");

	filter_reinit_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE15
		(sample_sel != sel_prev) |=> init_count == 2'h0 ##1 !$changed(filt_level))
		else $error("filter not reinitialised after clock change");

	analog_path_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE11
		!digital_filter_select |-> level[4] == sync2[4])
		else $error("pin 3 filtered while analog path selected");

	filter_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE7
		(wr_pending && wr_addr == OFS_FILTER_CTRL)
			|=> noise_filter_control == ($past(hwdata[7:0]) & MASK_FILTER))
		else $error("filter control write lost");

	pin3_wake_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RULE17
		(standby_mode && !pin3_can_wake && hit == 10'h010) |=> !wake_request)
		else $error("pin 3 woke with stopped sampling clock");
endmodule : ext_irq_edge_detect_filter

/* core/ext_irq_pkg.sv */
// constants, types and register map of the external interrupt edge detector
// assumes an AHB-Lite slave port on hclk, word-aligned 32-bit registers
// Function
// RULE1 - fall/rise bit pair selects none/rise/fall/both
// RULE2 - group0 bit2 nmi, bits3-6 pins0-3
// RULE3 - all selects reset to zero, nmi inactive
// RULE4 - group3 bit1 pair controls pin7
// RULE5 - group8 bit0 pair controls pin8
// RULE6 - group9 upper bits5-7 control pins4-6
// RULE7 - select registers byte and bit accessible
// RULE8 - clear selects before switching pin to port
// RULE9 - unused pins keep selects at zero
// RULE10 - shared receive pins: disable edge or receiver
// RULE11 - pin3 filter select: analog or digital
// RULE12 - three-bit code picks sampling clock
// RULE13 - three agreeing samples pass a level
// RULE14 - aligned short glitch may still pass
// RULE15 - clock change needs three ticks reinit
// RULE16 - software waits three ticks, clears flag
// RULE17 - stopped sampling clock blocks pin3 wake
// RULE18 - nmi detection independent of system clock filter
// RULE19 - two-stage synchroniser before edge compare
// RULE20 - one-cycle request per detected edge
package ext_irq_pkg;
	localparam logic [7:0] OFS_FALL_0       = 8'h00;
	localparam logic [7:0] OFS_RISE_0       = 8'h04;
	localparam logic [7:0] OFS_FALL_3       = 8'h08;
	localparam logic [7:0] OFS_RISE_3       = 8'h0C;
	localparam logic [7:0] OFS_FALL_8       = 8'h10;
	localparam logic [7:0] OFS_RISE_8       = 8'h14;
	localparam logic [7:0] OFS_FALL_9_UPPER = 8'h18;
	localparam logic [7:0] OFS_RISE_9_UPPER = 8'h1C;
	localparam logic [7:0] OFS_FILTER_CTRL  = 8'h20;
	localparam logic [7:0] OFS_STATUS       = 8'h24;

	localparam logic [7:0] RST_SELECT      = 8'h00;
	localparam logic [7:0] RST_FILTER_CTRL = 8'h00;

	// implemented bits; the rest read as zero
	localparam logic [7:0] MASK_GROUP0  = 8'h7C;
	localparam logic [7:0] MASK_GROUP3  = 8'h02;
	localparam logic [7:0] MASK_GROUP8  = 8'h01;
	localparam logic [7:0] MASK_GROUP9  = 8'hE0;
	localparam logic [7:0] MASK_FILTER  = 8'h87;

	localparam int NMI_BIT         = 2;
	localparam int GROUP0_FIRST    = 3;
	localparam int PIN7_BIT        = 1;
	localparam int PIN8_BIT        = 0;
	localparam int GROUP9_FIRST    = 5;
	localparam int FILTER_EN_BIT   = 7;
	localparam int STATUS_READY    = 10;

	localparam logic [2:0] SEL_DIV64   = 3'h0;
	localparam logic [2:0] SEL_DIV128  = 3'h1;
	localparam logic [2:0] SEL_DIV256  = 3'h2;
	localparam logic [2:0] SEL_DIV512  = 3'h3;
	localparam logic [2:0] SEL_DIV1024 = 3'h4;
	localparam logic [2:0] SEL_SUB     = 3'h5;

	localparam int         PRESCALE_BITS     = 10;
	localparam logic [1:0] FILTER_INIT_TICKS = 2'h3;

	typedef enum logic {BUS_IDLE, BUS_READ_WAIT} bus_state_t;
endpackage : ext_irq_pkg

/* verification/ext_irq_edge_detect_filter_bench.sv */
// self-checking bench for the external interrupt edge detector and pin 3 filter
// assumes pin_sources drives the pins and the bench is the only AHB-Lite master
`timescale 1ns/100ps
module ext_irq_edge_detect_filter_bench
	import ext_irq_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        standby_mode;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] dummy;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout;
	logic        hresp;
	logic        wake_request;
	logic        sub_clock;
	logic [9:0]  pin_level;
	logic [9:0]  req;
	logic [9:0]  lvl;
	logic [31:0] cnt [10];
	logic [31:0] wake_cnt;
	logic [7:0]  fr [4];
	logic [7:0]  rr [4];
	logic [7:0]  gmask [4] = '{MASK_GROUP0, MASK_GROUP3, MASK_GROUP8, MASK_GROUP9};
	logic [7:0]  fofs [4]  = '{OFS_FALL_0, OFS_FALL_3, OFS_FALL_8, OFS_FALL_9_UPPER};
	logic [7:0]  rofs [4]  = '{OFS_RISE_0, OFS_RISE_3, OFS_RISE_8, OFS_RISE_9_UPPER};
	int          failures;
	int          compares;
	int          seed;
	int          tick;

	pin_sources src (.pin_level(pin_level), .sub_clock(sub_clock));

	ext_irq_edge_detect_filter dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nmi_pin(pin_level[0]),
		.ext_request_pin_0(pin_level[1]), .ext_request_pin_1(pin_level[2]),
		.ext_request_pin_2(pin_level[3]), .ext_request_pin_3(pin_level[4]),
		.ext_request_pin_4(pin_level[5]), .ext_request_pin_5(pin_level[6]),
		.ext_request_pin_6(pin_level[7]), .ext_request_pin_7(pin_level[8]),
		.ext_request_pin_8(pin_level[9]), .sub_clock_pin(sub_clock),
		.standby_mode(standby_mode), .nmi_request(req[0]), .ext_request_0(req[1]),
		.ext_request_1(req[2]), .ext_request_2(req[3]), .ext_request_3(req[4]),
		.ext_request_4(req[5]), .ext_request_5(req[6]), .ext_request_6(req[7]),
		.ext_request_7(req[8]), .ext_request_8(req[9]), .wake_request(wake_request)
	);

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// pulse counters; an unknown pulse poisons the count
	always @(posedge hclk) begin
		if (hresetn === 1'b1) begin
			for (int i = 0; i < 10; i++) cnt[i] = cnt[i] + req[i];
			wake_cnt = wake_cnt + wake_request;
		end
	end

	function automatic int grp(input int i);
		return (i < 5) ? 0 : (i < 8) ? 3 : (i == 8) ? 1 : 2;
	endfunction : grp

	function automatic int bitn(input int i);
		return (i < 5) ? i + 2 : (i < 8) ? i : (i == 8) ? 1 : 0;
	endfunction : bitn

	task automatic stop_test();
		if (failures == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask : idle

	task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ahb(1'b1, a, d, dummy);
	endtask : wr

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 8'h00, r);
		check(name, r, exp);
		check("response", {31'h0, hresp}, 32'h0);
	endtask : rdchk

	task automatic clr();
		for (int i = 0; i < 10; i++) cnt[i] = 32'h0;
		wake_cnt = 32'h0;
	endtask : clr

	task automatic toggle(input logic [9:0] nv);
		logic e;
		logic any;
		clr();
		any = 1'b0;
		src.drive(nv);
		idle(10);
		for (int i = 0; i < 10; i++) begin
			e = (nv[i] & ~lvl[i] & rr[grp(i)][bitn(i)]) | (~nv[i] & lvl[i] & fr[grp(i)][bitn(i)]);
			any = any | e;
			check("edge request", cnt[i], {31'h0, e});
		end
		check("wake request", wake_cnt, {31'h0, any & standby_mode});
		lvl = nv;
	endtask : toggle

	initial begin
		#(40 * 60000);
		failures++;
		stop_test();
	end

	initial begin
		seed = 5515;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		standby_mode = 1'b0;
		lvl = 10'h000;
		clr();
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int k = 0; k < 9; k++) rdchk("reset value", 8'(k * 4), 32'h0);
		wr(8'h30, 8'hFF);
		rdchk("unmapped", 8'h30, 32'h0);
		for (int n = 0; n < 12; n++) begin
			for (int g = 0; g < 4; g++) begin
				fr[g] = (n == 1) ? 8'hFF : (n == 0) ? 8'h00 : 8'($random(seed));
				rr[g] = (n == 1) ? 8'hFF : (n == 0) ? 8'h00 : 8'($random(seed));
				wr(fofs[g], fr[g]);
				wr(rofs[g], rr[g]);
				rdchk("fall select", fofs[g], {24'h0, fr[g] & gmask[g]});
				rdchk("rise select", rofs[g], {24'h0, rr[g] & gmask[g]});
			end
			standby_mode <= n[0];
			toggle(lvl ^ 10'($random(seed)));
			toggle(~lvl);
		end
		// selects cleared before the pins go quiet and pin 3 is reused
		for (int g = 0; g < 4; g++) begin
			fr[g] = 8'h00;
			rr[g] = 8'h00;
			wr(fofs[g], 8'h00);
			wr(rofs[g], 8'h00);
		end
		toggle(10'h000);
		// let the pin 3 filter settle low before its clock is frozen
		idle(4 * 64);
		wr(OFS_FALL_0, 8'h40);
		wr(OFS_RISE_0, 8'h40);
		wr(OFS_FILTER_CTRL, 8'h07);
		standby_mode <= 1'b1;
		for (int c = 0; c < 6; c++) begin
			tick = (c == 5) ? 10 : (64 << c);
			wr(OFS_FILTER_CTRL, 8'h80 | 8'(c));
			rdchk("filter control", OFS_FILTER_CTRL, {24'h0, 8'h80 | 8'(c)});
			rdchk("filter not ready", OFS_STATUS, 32'h0);
			idle(4 * tick);
			rdchk("filter ready", OFS_STATUS, 32'h400);
			clr();
			src.drive(10'h010);
			idle(tick / 2);
			src.drive(10'h000);
			idle(4 * tick);
			check("glitch rejected", cnt[4], 32'h0);
			src.drive(10'h010);
			idle(5 * tick);
			rdchk("filtered level", OFS_STATUS, 32'h410);
			src.drive(10'h000);
			idle(5 * tick);
			check("filtered edges", cnt[4], 32'h2);
			check("standby wake", wake_cnt, (c == 5) ? 32'h2 : 32'h0);
		end
		stop_test();
	end
endmodule : ext_irq_edge_detect_filter_bench

/* verification/pin_sources.sv */
// behavioural sources for the nmi pin, the nine request pins and the subclock pin
// assumes the bench calls drive() right after a rising hclk edge; pins are asynchronous
`timescale 1ns/100ps
module pin_sources (
	output logic [9:0] pin_level,
	output logic       sub_clock
);
	// subclock oscillator keeps running in standby, phase unrelated to hclk
	initial begin
		pin_level = 10'h000;
		sub_clock = 1'b0;
		#13;
		forever #200 sub_clock = ~sub_clock;
	end

	// a level holds until the next drive; analog delay filters are pass-through
	task automatic drive(input logic [9:0] v);
		pin_level <= v;
	endtask : drive
endmodule : pin_sources
